// file: core/acl_cmd_port.sv
// AC-link command port: codec register access over slots 1 and 2
`default_nettype none
// Summary of operation
// - A command issued by software goes out in slots 1 and 2 of the next frame, never the current.
// - Write completion and arrival of read data set status flags and can raise the interrupt.
// - The issue bit makes the next frame carry the register pointer and any write payload.
// - The issue bit clears itself once address and data have been shifted out.
// - A read uses slot 1 only; slot 2 carries payload only for a write.
// - The 16-bit payload in bits 23 to 8 goes out in slot 2 when the direction bit is 0.
// - The direction bit 7 goes out as the read/write bit of slot 1, 1 meaning read.
// - The 7-bit pointer in bits 6 to 0 goes out in the address field of slot 1.
// - Power-down is a normal register write with the power-down flag bit 25 also set.
// - With that flag set, all link outputs go low once slot 2 of the command is sent.
// - Only a warm reset brings the link out of power-down.
// - A warm reset holds frame sync high for 1 us and its request bit then clears itself.
// - Read-valid clears when a new read is requested and sets when the codec returns data.
// - The register index echoed by the codec is captured with the read data.
module acl_cmd_port #(
    parameter logic [1:0] CODEC_ID = 2'h0
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic             hresp,
    input  wire logic        bitClkPin,
    input  wire logic        sdataInPin,
    output logic             acSync,
    output logic             acSdataOut,
    output logic             irq
);
    logic                        wrEn_q;
    logic [7:0]                  wrAddr_q;
    logic                        cmdPdown_q;
    logic                        cmdEna_q;
    logic [15:0]                 cmdWdata_q;
    logic                        cmdRw_q;
    logic [6:0]                  cmdIdx_q;
    logic                        warmReq_q;
    logic [1:0]                  irqStat_q;
    logic [1:0]                  irqMask_q;
    logic                        readValid_q;
    logic                        readPend_q;
    logic                        codecReady_q;
    logic                        rxTag1_q;
    logic                        rxTag2_q;
    logic [6:0]                  rxIdx_q;
    logic [6:0]                  echoIdx_q;
    logic [15:0]                 readData_q;
    logic [19:0]                 rxShift_q;
    logic [19:0]                 rxWord;
    logic [1:0]                  pinS;
    logic                        bitClkD_q;
    logic                        bitRise;
    logic                        bitFall;
    acl_pkg::acl_link_state_type state_q;
    logic [3:0]                  slot_q;
    logic [4:0]                  bit_q;
    logic [3:0]                  nextSlot;
    logic [19:0]                 slotWord;
    logic [19:0]                 txWord_q;
    logic                        cmdFrame_q;
    logic [6:0]                  warmCnt_q;
    logic                        warmDone;
    logic                        cmdEnd;
    logic                        readDone;
    logic                        cmdWr;
    logic                        ctrlWr;
    logic                        maskWr;
    logic                        statWr;
    logic [31:0]                 rdMux;

    // Pins
    acl_sync #(.WIDTH(2)) pinSync (
        .core_clk (core_clk),
        .rst      (rst),
        .asyncIn  ({bitClkPin, sdataInPin}),
        .syncOut  (pinS)
    );

    always_ff @(posedge core_clk) begin
        if (rst) begin
            bitClkD_q <= 1'b0;
        end else begin
            bitClkD_q <= pinS[1];
        end
    end

    assign bitRise = pinS[1] & ~bitClkD_q;
    assign bitFall = ~pinS[1] & bitClkD_q;

    // AHB-Lite slave, zero wait states
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign cmdWr     = wrEn_q && wrAddr_q == acl_pkg::CMD_OFS;
    assign ctrlWr    = wrEn_q && wrAddr_q == acl_pkg::CTRL_OFS;
    assign maskWr    = wrEn_q && wrAddr_q == acl_pkg::IRQ_MASK_OFS;
    assign statWr    = wrEn_q && wrAddr_q == acl_pkg::IRQ_STAT_OFS;

    always_comb begin
        case (haddr[7:0])
            acl_pkg::CMD_OFS:      rdMux = {6'h00, cmdPdown_q, cmdEna_q, cmdWdata_q,
                                            cmdRw_q, cmdIdx_q};
            acl_pkg::STAT_OFS:     rdMux = {7'h00, codecReady_q, readValid_q, echoIdx_q,
                                            readData_q};
            acl_pkg::IRQ_STAT_OFS: rdMux = {30'h0000_0000, irqStat_q};
            acl_pkg::IRQ_MASK_OFS: rdMux = {30'h0000_0000, irqMask_q};
            acl_pkg::CTRL_OFS:     rdMux = {31'h0000_0000, warmReq_q};
            default:               rdMux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wrEn_q   <= 1'b0;
            wrAddr_q <= 8'h00;
            hrdata   <= 32'h0000_0000;
        end else if (hready) begin
            wrEn_q   <= hsel && htrans[1] && hwrite && hsize == 3'h2;
            wrAddr_q <= haddr[7:0];
            if (hsel && htrans[1] && !hwrite) begin
                hrdata <= rdMux;
            end
        end
    end

    // Command word; a software write of the issue bit wins over the self-clear
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cmdPdown_q <= acl_pkg::CMD_RESET[acl_pkg::CMD_PDOWN_BIT];
            cmdEna_q   <= acl_pkg::CMD_RESET[acl_pkg::CMD_ISSUE_BIT];
            cmdWdata_q <= acl_pkg::CMD_RESET[acl_pkg::CMD_WDATA_LSB +: 16];
            cmdRw_q    <= acl_pkg::CMD_RESET[acl_pkg::CMD_RW_BIT];
            cmdIdx_q   <= acl_pkg::CMD_RESET[acl_pkg::CMD_IDX_LSB +: 7];
        end else begin
            if (cmdEnd) begin
                cmdEna_q <= 1'b0;
            end
            if (cmdWr) begin
                cmdPdown_q <= hwdata[acl_pkg::CMD_PDOWN_BIT];
                cmdEna_q   <= hwdata[acl_pkg::CMD_ISSUE_BIT];
                cmdWdata_q <= hwdata[acl_pkg::CMD_WDATA_LSB +: 16];
                cmdRw_q    <= hwdata[acl_pkg::CMD_RW_BIT];
                cmdIdx_q   <= hwdata[acl_pkg::CMD_IDX_LSB +: 7];
            end
        end
    end

    // Warm reset request; the request set wins over its own completion
    always_ff @(posedge core_clk) begin
        if (rst) begin
            warmReq_q <= 1'b0;
        end else begin
            if (warmDone) begin
                warmReq_q <= 1'b0;
            end
            if (ctrlWr && hwdata[acl_pkg::CTRL_WARM_BIT]) begin
                warmReq_q <= 1'b1;
            end
        end
    end

    // Interrupt status, write one to clear, events win
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irqStat_q <= 2'h0;
            irqMask_q <= acl_pkg::IRQ_MASK_RESET;
        end else begin
            irqStat_q <= (irqStat_q & ~(statWr ? hwdata[1:0] : 2'h0))
                       | {readDone, cmdEnd && !cmdRw_q};
            if (maskWr) begin
                irqMask_q <= hwdata[1:0];
            end
        end
    end

    assign irq = |(irqStat_q & irqMask_q);

    // Frame transmit side
    assign nextSlot = (slot_q == acl_pkg::LAST_SLOT) ? 4'h0 : slot_q + 4'h1;
    assign cmdEnd   = bitRise && state_q == acl_pkg::ST_RUN && slot_q == 4'h2
                      && bit_q == 5'h00 && cmdFrame_q;
    assign warmDone = state_q == acl_pkg::ST_WARM
                      && warmCnt_q == 7'(acl_pkg::WARM_CYC - 1);

    always_comb begin
        case (nextSlot)
            4'h0:    slotWord = {cmdEna_q, cmdEna_q, cmdEna_q & ~cmdRw_q, 11'h000,
                                 CODEC_ID, 4'h0};
            4'h1:    slotWord = cmdFrame_q ? {cmdRw_q, cmdIdx_q, 12'h000}
                                           : 20'h00000;
            4'h2:    slotWord = (cmdFrame_q && !cmdRw_q) ? {cmdWdata_q, 4'h0}
                                                         : 20'h00000;
            default: slotWord = 20'h00000;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q    <= acl_pkg::ST_RUN;
            slot_q     <= acl_pkg::LAST_SLOT;
            bit_q      <= 5'h00;
            txWord_q   <= 20'h00000;
            acSdataOut <= 1'b0;
            acSync     <= 1'b0;
            cmdFrame_q <= 1'b0;
            warmCnt_q  <= 7'h00;
        end else begin
            case (state_q)
                acl_pkg::ST_RUN: begin
                    if (warmReq_q) begin
                        state_q    <= acl_pkg::ST_WARM;
                        warmCnt_q  <= 7'h00;
                        acSync     <= 1'b1;
                        acSdataOut <= 1'b0;
                        cmdFrame_q <= 1'b0;
                    end else if (cmdEnd && cmdPdown_q) begin
                        state_q    <= acl_pkg::ST_PDOWN;
                        acSync     <= 1'b0;
                        acSdataOut <= 1'b0;
                        cmdFrame_q <= 1'b0;
                    end else if (bitRise && bit_q == 5'h00) begin
                        slot_q     <= nextSlot;
                        bit_q      <= (nextSlot == 4'h0) ? acl_pkg::SLOT0_LAST
                                                         : acl_pkg::SLOT_LAST;
                        acSdataOut <= slotWord[19];
                        txWord_q   <= {slotWord[18:0], 1'b0};
                        acSync     <= nextSlot == 4'h0;
                        if (nextSlot == 4'h0) begin
                            cmdFrame_q <= cmdEna_q;
                        end
                    end else if (bitRise) begin
                        bit_q      <= bit_q - 5'h01;
                        acSdataOut <= txWord_q[19];
                        txWord_q   <= {txWord_q[18:0], 1'b0};
                    end
                end
                acl_pkg::ST_PDOWN: begin
                    // Bit clock stops here; only a warm reset leaves
                    if (warmReq_q) begin
                        state_q   <= acl_pkg::ST_WARM;
                        warmCnt_q <= 7'h00;
                        acSync    <= 1'b1;
                    end
                end
                acl_pkg::ST_WARM: begin
                    warmCnt_q <= warmCnt_q + 7'h01;
                    if (warmDone) begin
                        state_q <= acl_pkg::ST_RUN;
                        acSync  <= 1'b0;
                        slot_q  <= acl_pkg::LAST_SLOT;
                        bit_q   <= 5'h00;
                    end
                end
                default: begin
                    state_q <= acl_pkg::ST_RUN;
                end
            endcase
        end
    end

    // Frame receive side, sampled on the falling bit clock edge
    assign rxWord   = {rxShift_q[18:0], pinS[0]};
    assign readDone = bitFall && state_q == acl_pkg::ST_RUN && slot_q == 4'h2
                      && bit_q == 5'h00 && readPend_q && rxTag1_q && rxTag2_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rxShift_q    <= 20'h00000;
            codecReady_q <= 1'b0;
            rxTag1_q     <= 1'b0;
            rxTag2_q     <= 1'b0;
            rxIdx_q      <= 7'h00;
        end else if (bitFall && state_q == acl_pkg::ST_RUN) begin
            rxShift_q <= rxWord;
            if (bit_q == 5'h00 && slot_q == 4'h0) begin
                codecReady_q <= rxWord[15];
                rxTag1_q     <= rxWord[14];
                rxTag2_q     <= rxWord[13];
            end
            if (bit_q == 5'h00 && slot_q == 4'h1) begin
                rxIdx_q <= rxWord[18:12];
            end
        end
    end

    // Read tracking; data arrival wins over a clear by a new request
    always_ff @(posedge core_clk) begin
        if (rst) begin
            readPend_q  <= 1'b0;
            readValid_q <= 1'b0;
            echoIdx_q   <= 7'h00;
            readData_q  <= 16'h0000;
        end else begin
            if (cmdEnd && cmdRw_q) begin
                readPend_q <= 1'b1;
            end else if (readDone) begin
                readPend_q <= 1'b0;
            end
            if (cmdWr && hwdata[acl_pkg::CMD_ISSUE_BIT] && hwdata[acl_pkg::CMD_RW_BIT]) begin
                readValid_q <= 1'b0;
            end
            if (readDone) begin
                readValid_q <= 1'b1;
                echoIdx_q   <= rxIdx_q;
                readData_q  <= rxWord[19:4];
            end
        end
    end

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_next_frame: assert property ($rose(cmdFrame_q) |-> slot_q == 4'h0 && acSync)
        else $error("command frame did not start at slot 0");
    a_write_flag: assert property (cmdEnd && !cmdRw_q |=> irqStat_q[acl_pkg::IRQ_WDONE_BIT])
        else $error("write completion flag not set");
    a_issue_load: assert property (bitRise && state_q == acl_pkg::ST_RUN && !warmReq_q
        && bit_q == 5'h00 && slot_q == acl_pkg::LAST_SLOT && cmdEna_q |=> cmdFrame_q)
        else $error("issued command not taken into frame");
    a_issue_clear: assert property (cmdEnd && !cmdWr |=> !cmdEna_q)
        else $error("issue bit did not clear");
    a_read_slot2: assert property (slot_q == 4'h2 && cmdFrame_q && cmdRw_q |-> !acSdataOut)
        else $error("read drove slot 2");
    a_wdata_msb: assert property (cmdEnd == 1'b0 && bitRise && slot_q == 4'h1 && bit_q == 5'h00
        && cmdFrame_q && !cmdRw_q && state_q == acl_pkg::ST_RUN && !warmReq_q
        |=> acSdataOut == cmdWdata_q[15])
        else $error("payload MSB wrong in slot 2");
    a_rw_bit: assert property (bitRise && slot_q == 4'h0 && bit_q == 5'h00 && cmdFrame_q
        && state_q == acl_pkg::ST_RUN && !warmReq_q |=> acSdataOut == cmdRw_q && slot_q == 4'h1)
        else $error("direction bit wrong in slot 1");
    a_pdown_quiet: assert property (state_q == acl_pkg::ST_PDOWN |-> !acSync && !acSdataOut)
        else $error("link active in power-down");
    a_warm_pulse: assert property ($rose(state_q == acl_pkg::ST_WARM) |-> acSync [*8])
        else $error("warm sync pulse too short");
    a_warm_end: assert property (warmDone && !ctrlWr |=> state_q == acl_pkg::ST_RUN
        && !acSync && !warmReq_q)
        else $error("warm reset did not end after 1 us");
    a_read_done: assert property (readDone |=> readValid_q && echoIdx_q == $past(rxIdx_q))
        else $error("read data not captured");

    c_write_cmd: cover property (cmdEnd && !cmdRw_q);
    c_read_back: cover property (readDone);
    c_pdown: cover property (state_q == acl_pkg::ST_PDOWN);
    c_warm: cover property (warmDone);
endmodule : acl_cmd_port
`default_nettype wire

// file: core/acl_pkg.sv
// Shared constants and types of the AC-link command port
`default_nettype none
package acl_pkg;
    // Register byte offsets
    localparam logic [7:0] CMD_OFS      = 8'h20;
    localparam logic [7:0] STAT_OFS     = 8'h24;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h30;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h34;
    localparam logic [7:0] CTRL_OFS     = 8'h38;
    // Command word fields
    localparam int CMD_PDOWN_BIT = 25;
    localparam int CMD_ISSUE_BIT = 24;
    localparam int CMD_WDATA_LSB = 8;
    localparam int CMD_RW_BIT    = 7;
    localparam int CMD_IDX_LSB   = 0;
    // Status word fields
    localparam int STAT_READY_BIT = 24;
    localparam int STAT_VALID_BIT = 23;
    localparam int STAT_ECHO_LSB  = 16;
    // Interrupt and control fields
    localparam int IRQ_WDONE_BIT = 0;
    localparam int IRQ_RDONE_BIT = 1;
    localparam int CTRL_WARM_BIT = 0;
    // Reset values
    localparam logic [31:0] CMD_RESET      = 32'h0000_0000;
    localparam logic [1:0]  IRQ_MASK_RESET = 2'h0;
    // Frame layout
    localparam logic [3:0] LAST_SLOT  = 4'hC;
    localparam logic [4:0] SLOT0_LAST = 5'h0F;
    localparam logic [4:0] SLOT_LAST  = 5'h13;
    // Timing
    localparam int CLK_NS   = 20;
    localparam int WARM_NS  = 1000;
    localparam int WARM_CYC = (WARM_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [1:0] {ST_RUN, ST_PDOWN, ST_WARM} acl_link_state_type;
endpackage : acl_pkg
`default_nettype wire

// file: core/acl_sync.sv
// Two-flop synchroniser for pins from outside the core clock domain
`default_nettype none
module acl_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_q  <= '0;
            syncOut <= '0;
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule : acl_sync
`default_nettype wire

// file: tb/acl_codec_model.sv
// Behavioural codec at the far end of the AC-link
`default_nettype none
module acl_codec_model (
    output logic        bitClk,
    output logic        sdataIn  = 1'b0,
    input  wire logic   syncPin,
    input  wire logic   sdataOut,
    output logic [7:0]  bitIdx   = 8'h00,
    output logic [15:0] frameCnt = 16'h0000,
    output logic [15:0] txTag,
    output logic [19:0] txSlot1,
    output logic [19:0] txSlot2
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        syncLast = 1'b0;
    logic [55:0] shiftIn;
    logic        pending  = 1'b0;
    logic        replying = 1'b0;
    logic [6:0]  replyIdx = 7'h00;

    // Reply frame: ready, slot valid bits, echoed index, data made from the index
    function automatic logic rx_bit(input logic [7:0] b, input logic rep, input logic [6:0] ri);
        logic [55:0] word;
        word = {1'b1, rep, rep, 13'h0, 1'b0, ri, 12'h0, 1'b1, ri, ~ri, 1'b0, 4'h0};
        return (b < 8'd56) ? word[8'd55 - b] : 1'b0;
    endfunction : rx_bit

    // Free-running bit clock, phase unrelated to the core clock
    initial begin
        bitClk = 1'b0;
        #7;
        forever #80 bitClk = ~bitClk;
    end

    // Sample at the rise, well clear of the controller's launch point
    always @(posedge bitClk) begin : sample
        logic [7:0]  cur;
        logic [55:0] full;
        cur = (syncPin && !syncLast) ? 8'h00 : bitIdx + 8'h01;
        full = {shiftIn[54:0], sdataOut};
        syncLast <= syncPin;
        bitIdx <= cur;
        shiftIn <= full;
        if (cur == 8'd55) begin
            frameCnt <= frameCnt + 16'h1;
            txTag <= full[55:40];
            txSlot1 <= full[39:20];
            txSlot2 <= full[19:0];
            pending <= full[54] && full[39];
            replyIdx <= full[38:32];
        end
        if (cur == 8'hFF) begin
            replying <= pending;
            pending <= 1'b0;
        end
        sdataIn <= rx_bit(cur + 8'h01, (cur == 8'hFF) ? pending : replying, replyIdx);
    end
endmodule : acl_codec_model
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the AC-link command port
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [1:0] CODEC_ID = 2'h2;
    logic        core_clk;
    logic        rst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        bitClk;
    logic        sdataIn;
    logic        acSync;
    logic        acSdataOut;
    logic        irq;
    logic [7:0]  bitIdx;
    logic [15:0] frameCnt;
    logic [15:0] txTag;
    logic [19:0] txSlot1;
    logic [19:0] txSlot2;
    logic [31:0] rngState;
    logic [31:0] rdVal;
    logic        idleOr;
    int          badCount;
    int          nCompared;
    int          n;

    acl_cmd_port #(.CODEC_ID(CODEC_ID)) dut (
        .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .bitClkPin(bitClk),
        .sdataInPin(sdataIn), .acSync(acSync), .acSdataOut(acSdataOut), .irq(irq));

    acl_codec_model codec (
        .bitClk(bitClk), .sdataIn(sdataIn), .syncPin(acSync), .sdataOut(acSdataOut),
        .bitIdx(bitIdx), .frameCnt(frameCnt), .txTag(txTag), .txSlot1(txSlot1),
        .txSlot2(txSlot2));

    initial core_clk = 1'b0;
    always #10 core_clk = ~core_clk;

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    function automatic logic [31:0] exp_status(input logic [6:0] ri);
        return {7'h0, 1'b1, 1'b1, ri, 1'b1, ri, ~ri, 1'b0};
    endfunction : exp_status

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            badCount++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check32

    task automatic expire;
        badCount++;
        $display("ERROR at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
        results();
    endtask : expire

    task automatic wait_ready;
        int k;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1) expire();
    endtask : wait_ready

    // One single-word transfer; read data taken at the data phase's ready edge
    task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, ofs};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rdVal = hrdata;
    endtask : ahb

    task automatic wait_frame;
        logic [15:0] start;
        int k;
        start = frameCnt;
        k = 0;
        while (frameCnt === start && k < 3000) begin
            @(posedge core_clk);
            k++;
        end
        if (frameCnt === start) expire();
    endtask : wait_frame

    task automatic do_cmd(input logic [31:0] cmd, input logic expIrq);
        logic rw;
        int k;
        rw = cmd[7];
        k = 0;
        while (bitIdx !== 8'd4 && k < 3000) begin
            @(posedge core_clk);
            k++;
        end
        if (bitIdx !== 8'd4) expire();
        // Issued just after slot 0 began, so this frame must stay idle
        ahb(1'b1, acl_pkg::CMD_OFS, cmd | 32'h0100_0000);
        wait_frame();
        check32({16'h0, txTag}, {30'h0, CODEC_ID});
        wait_frame();
        check32({16'h0, txTag}, {16'h0, 1'b1, 1'b1, !rw, 11'h0, CODEC_ID});
        check32({12'h0, txSlot1}, {12'h0, rw, cmd[6:0], 12'h0});
        check32({12'h0, txSlot2}, rw ? 32'h0 : {12'h0, cmd[23:8], 4'h0});
        repeat (10) @(posedge core_clk);
        ahb(1'b0, acl_pkg::CMD_OFS, 32'h0);
        check32(rdVal, cmd);
        ahb(1'b0, acl_pkg::IRQ_STAT_OFS, 32'h0);
        check32(rdVal, {31'h0, !rw});
        if (rw) begin
            ahb(1'b0, acl_pkg::STAT_OFS, 32'h0);
            check32({31'h0, rdVal[23]}, 32'h0);
            wait_frame();
            repeat (10) @(posedge core_clk);
            ahb(1'b0, acl_pkg::STAT_OFS, 32'h0);
            check32(rdVal, exp_status(cmd[6:0]));
            ahb(1'b0, acl_pkg::IRQ_STAT_OFS, 32'h0);
            check32(rdVal, 32'h2);
        end
        check32({31'h0, irq}, {31'h0, expIrq});
        ahb(1'b1, acl_pkg::IRQ_STAT_OFS, 32'h3);
        ahb(1'b0, acl_pkg::IRQ_STAT_OFS, 32'h0);
        check32({irq, rdVal[30:0]}, 32'h0);
    endtask : do_cmd

    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        rst = 1'b1;
        rngState = 32'h34453154;
        badCount = 0;
        nCompared = 0;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        ahb(1'b0, acl_pkg::CMD_OFS, 32'h0);
        check32(rdVal, acl_pkg::CMD_RESET);
        // Byte-sized write is refused, so the mask keeps its reset value
        hsize <= 3'b000;
        ahb(1'b1, acl_pkg::IRQ_MASK_OFS, 32'h3);
        hsize <= 3'b010;
        ahb(1'b0, acl_pkg::IRQ_MASK_OFS, 32'h0);
        check32(rdVal, {30'h0, acl_pkg::IRQ_MASK_RESET});
        check32({31'h0, hresp}, 32'h0);
        // Unmapped place: write ignored, reads zero
        ahb(1'b1, 8'h10, 32'hFFFF_FFFF);
        ahb(1'b0, 8'h10, 32'h0);
        check32(rdVal, 32'h0);
        for (int i = 0; i < 6; i++) begin
            rngState = xorshift(rngState);
            ahb(1'b1, acl_pkg::IRQ_MASK_OFS, i[0] ? 32'h0 : 32'h3);
            do_cmd({8'h0, rngState[31:16], i >= 2, rngState[6:0]}, !i[0]);
        end
        // Power-down: a plain write with the flag set
        rngState = xorshift(rngState);
        do_cmd({6'h0, 1'b1, 1'b0, rngState[15:0], 1'b0, 7'h26}, 1'b0);
        idleOr = 1'b0;
        repeat (600) begin
            @(posedge core_clk);
            idleOr = idleOr | acSync | acSdataOut;
        end
        check32({31'h0, idleOr}, 32'h0);
        ahb(1'b1, acl_pkg::CMD_OFS, 32'h0);
        ahb(1'b1, acl_pkg::CTRL_OFS, 32'h1);
        n = 0;
        while (acSync !== 1'b1 && n < 10) begin
            @(posedge core_clk);
            n++;
        end
        n = 0;
        while (acSync === 1'b1 && n < 100) begin
            @(posedge core_clk);
            n++;
        end
        check32(n, 32'd50);
        ahb(1'b0, acl_pkg::CTRL_OFS, 32'h0);
        check32(rdVal, 32'h0);
        n = 0;
        while (acSync !== 1'b1 && n < 400) begin
            @(posedge core_clk);
            n++;
        end
        check32({31'h0, acSync}, 32'h1);
        results();
    end
endmodule : testbench
`default_nettype wire
